// ---- logic/charger_pkg.sv ----
// Shared constants for the charger command link and set-point registers
package charger_pkg;
    // ****************************************
    // Command bytes
    // ****************************************
    localparam logic [7:0] CMD_MODE = 8'h12;
    localparam logic [7:0] CMD_CURRENT = 8'h14;
    localparam logic [7:0] CMD_VOLTAGE = 8'h15;
    // ****************************************
    // Mode word bit positions
    // ****************************************
    localparam int MODE_INHIBIT_BIT = 0;
    localparam int MODE_DEFAULTS_BIT = 2;
    localparam int MODE_BATT_MASK_BIT = 5;
    localparam int MODE_PFAIL_MASK_BIT = 6;
    localparam int MODE_OVERTEMP_STOP_BIT_BIT = 10;
    // Bits the host must write as zero and as one
    localparam logic [15:0] MODE_MUST_ZERO = 16'h000A;
    localparam logic [15:0] MODE_MUST_ONE = 16'hFB90;
    // ****************************************
    // Reset and default values
    // ****************************************
    localparam logic [15:0] VOLT_RESET = 16'hFFF0;
    localparam logic [15:0] VOLT_DEFAULT = 16'hFFFF;
    localparam logic [15:0] CUR_DEFAULT = 16'h00C0;
    localparam logic [15:0] CUR_RESET = 16'h0000;
    localparam logic INHIBIT_RESET = 1'b0;
    localparam logic BATT_MASK_RESET = 1'b0;
    localparam logic PFAIL_MASK_RESET = 1'b1;
    localparam logic OVERTEMP_STOP_BIT_RESET = 1'b1;
    // ****************************************
    // Voltage word fields
    // ****************************************
    localparam int VOLT_DAC_LSB = 4;
    localparam int VOLT_DAC_MSB = 13;
    localparam int VOLT_OR_LSB = 14;
    localparam int VOLT_OR_MSB = 15;
    localparam int DAC_W = 10;
    localparam logic [15:0] VOLT_MIN_ON = 16'h0010;
    // ****************************************
    // Maintenance source and range strap
    // ****************************************
    localparam int TRICKLE_W = 5;
    localparam logic [15:0] CUR_TRICKLE_FULL = 16'h0020;
    localparam logic [4:0] TRICKLE_MAX = 5'h1F;
    localparam logic [1:0] SEL_GND = 2'h0;
    localparam logic [1:0] SEL_OPEN = 2'h1;
    localparam logic [1:0] SEL_SUPPLY = 2'h2;
    localparam logic [15:0] CUR_MAX_GND = 16'h03FF;
    localparam logic [15:0] CUR_MAX_OPEN = 16'h07FF;
    localparam logic [15:0] CUR_MAX_SUPPLY = 16'h0FFF;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b01,
        HOST_SEND = 2'b10
    } host_state_t;
endpackage

// ---- logic/word_link_if.sv ----
// Word-write link between the command host and the charger register block
`timescale 1ns/1ps
interface word_link_if;
    logic wr_valid;
    logic [7:0] wr_cmd;
    logic [15:0] wr_data;
    logic wr_ack;
    modport charger (
        input wr_valid,
        input wr_cmd,
        input wr_data,
        output wr_ack
    );
    modport host (
        output wr_valid,
        output wr_cmd,
        output wr_data,
        input wr_ack
    );
endinterface

// ---- logic/charger_setpoint_command_regs.sv ----
// Charger set-point, mode and maintenance-source control registers
//
// Behaviour
// [R1] Voltage command 0x15 carries millivolt set point
// [R2] Low four voltage bits are ignored
// [R3] Top bits clear: load DAC, clear over-range
// [R4] Either top bit set: DAC all ones, over-range
// [R5] Mode bit 0 inhibits charging, sets flag
// [R6] Host writes zero to mode bits 1, 3
// [R7] Host writes one to unused mode bits
// [R8] Mode bit 2 reloads defaults, clears latches
// [R9] Mode bit 5 masks battery-presence edge interrupt
// [R10] Mode bit 6 masks power-fail edge interrupt
// [R11] Mode bit 10 lets overtemp stop charging
// [R12] Voltage set point resets to 0xFFF0
// [R13] Battery absent restores voltage reset value
// [R14] Current command 0x14 carries milliamp set point
// [R15] Range strap selects maximum current set point
// [R16] Comp-low flag turns maintenance source off while clamp is not active
// [R17] Clamp active drives voltage-unregulated flag
// [R18] Small current word gives 1-31 mA
// [R19] Large current word gives fixed 31 mA
// [R20] Inhibit conditions force maintenance source off
// [R21] Overtemp_stop_bit is hot, bit, not under-range
// [R22] Battery absent forces overtemp_stop_bit bit set
// [R23] Mode command 0x12 maps bits directly
// [R24] Registers update whole on acknowledged write
`timescale 1ns/1ps
module charger_setpoint_command_regs
    import charger_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    word_link_if.charger link,
    input wire logic batt_present_i,
    input wire logic power_fail_i,
    input wire logic overtemp_i,
    input wire logic therm_underrange_i,
    input wire logic comp_low_i,
    input wire logic clamp_active_i,
    input wire logic alarm_set_i,
    input wire logic [1:0] range_sel_i,
    output logic [DAC_W-1:0] voltage_dac_code_o,
    output logic voltage_or_o,
    output logic [15:0] voltage_setpoint_o,
    output logic [15:0] current_setpoint_o,
    output logic [15:0] current_limit_o,
    output logic charge_off_status_o,
    output logic overtemp_stop_bit_o,
    output logic overtemp_flag_o,
    output logic alarm_block_flag_o,
    output logic voltage_unregulated_flag_o,
    output logic overtemp_stop_bit_active_o,
    output logic charger_off_o,
    output logic [TRICKLE_W-1:0] trickle_source_o,
    output logic irq_event_o
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    assign pins_raw = {range_sel_i, alarm_set_i, clamp_active_i, comp_low_i,
                       therm_underrange_i, overtemp_i, power_fail_i, batt_present_i};
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pins_raw;
            sync_b <= sync_a;
        end
    end
    logic batt_s;
    logic pfail_s;
    logic hot_s;
    logic underrange_s;
    logic comp_low_s;
    logic clamp_s;
    logic alarm_s;
    logic [1:0] sel_s;
    assign {sel_s, alarm_s, clamp_s, comp_low_s, underrange_s, hot_s, pfail_s, batt_s} = sync_b;

    // ****************************************
    // Command decode
    // ****************************************
    logic wr_mode;
    logic wr_volt;
    logic wr_cur;
    // Every offered word is acknowledged; unknown commands are dropped
    assign link.wr_ack = link.wr_valid;
    assign wr_mode = link.wr_valid && link.wr_cmd == CMD_MODE; // [R23] [R24]
    assign wr_volt = link.wr_valid && link.wr_cmd == CMD_VOLTAGE; // [R1] [R24]
    assign wr_cur = link.wr_valid && link.wr_cmd == CMD_CURRENT; // [R14] [R24]

    // ****************************************
    // Register state
    // ****************************************
    logic [15:0] volt_sp;
    logic [15:0] cur_sp;
    logic inhibit;
    logic batt_mask;
    logic pfail_mask;
    logic overtemp_stop_bit;
    logic hot_latch;
    logic alarm_latch;
    logic batt_d;
    logic pfail_d;
    logic [DAC_W-1:0] dac;
    logic vor;
    logic [TRICKLE_W-1:0] trickle;
    logic irq;
    logic [15:0] limit;
    logic unreg;
    logic [15:0] next_volt_sp;
    logic [15:0] next_cur_sp;
    logic next_inhibit;
    logic next_batt_mask;
    logic next_pfail_mask;
    logic next_overtemp_stop_bit;
    logic next_hot_latch;
    logic next_alarm_latch;
    logic [DAC_W-1:0] next_dac;
    logic next_vor;
    logic [TRICKLE_W-1:0] next_trickle;
    logic next_irq;
    logic [15:0] next_limit;
    logic overtemp_stop_bit_cond;
    logic off_cond;
    logic [15:0] cur_max;

    assign overtemp_stop_bit_cond = hot_latch && overtemp_stop_bit && !underrange_s; // [R21] [R11]
    assign off_cond = inhibit || overtemp_stop_bit_cond; // [R5] [R11]

    always_comb begin
        next_volt_sp = volt_sp;
        next_cur_sp = cur_sp;
        next_inhibit = inhibit;
        next_batt_mask = batt_mask;
        next_pfail_mask = pfail_mask;
        next_overtemp_stop_bit = overtemp_stop_bit;
        // Latched flags: a new set wins over a simultaneous clear
        next_hot_latch = hot_latch;
        next_alarm_latch = alarm_latch;
        if (wr_volt) begin
            next_volt_sp = link.wr_data; // [R1]
        end
        if (wr_cur) begin
            next_cur_sp = link.wr_data; // [R14]
        end
        if (wr_mode) begin
            next_inhibit = link.wr_data[MODE_INHIBIT_BIT]; // [R5]
            next_batt_mask = link.wr_data[MODE_BATT_MASK_BIT]; // [R9]
            next_pfail_mask = link.wr_data[MODE_PFAIL_MASK_BIT]; // [R10]
            next_overtemp_stop_bit = link.wr_data[MODE_OVERTEMP_STOP_BIT_BIT]; // [R11]
            if (link.wr_data[MODE_DEFAULTS_BIT]) begin
                next_volt_sp = VOLT_DEFAULT; // [R8]
                next_cur_sp = CUR_DEFAULT; // [R8]
                next_hot_latch = 1'b0; // [R8]
                next_alarm_latch = 1'b0; // [R8]
            end
        end
        if (!batt_s) begin
            next_volt_sp = VOLT_RESET; // [R13]
            next_overtemp_stop_bit = OVERTEMP_STOP_BIT_RESET; // [R22]
            next_hot_latch = 1'b0;
            next_alarm_latch = 1'b0;
        end
        if (hot_s) begin
            next_hot_latch = 1'b1;
        end
        if (alarm_s) begin
            next_alarm_latch = 1'b1;
        end
    end

    // ****************************************
    // Voltage DAC mapping
    // ****************************************
    always_comb begin
        if (volt_sp[VOLT_OR_MSB:VOLT_OR_LSB] == 2'h0) begin
            next_dac = volt_sp[VOLT_DAC_MSB:VOLT_DAC_LSB]; // [R2] [R3]
            next_vor = 1'b0; // [R3]
        end else begin
            next_dac = '1; // [R4]
            next_vor = 1'b1; // [R4]
        end
    end

    // ****************************************
    // Range strap current limit
    // ****************************************
    always_comb begin
        case (sel_s)
            SEL_GND: cur_max = CUR_MAX_GND; // [R15]
            SEL_OPEN: cur_max = CUR_MAX_OPEN; // [R15]
            SEL_SUPPLY: cur_max = CUR_MAX_SUPPLY; // [R15]
            default: cur_max = CUR_MAX_OPEN;
        endcase
        next_limit = (cur_sp > cur_max) ? cur_max : cur_sp; // [R15]
    end

    // ****************************************
    // Maintenance source
    // ****************************************
    always_comb begin
        if (off_cond || alarm_latch || cur_sp == 16'h0000 || volt_sp < VOLT_MIN_ON) begin
            next_trickle = '0; // [R20]
        end else if (comp_low_s && !clamp_s) begin
            // Stops overshoot of the voltage set point
            next_trickle = '0; // [R16] [R18] [R19]
        end else if (cur_sp >= CUR_TRICKLE_FULL) begin
            next_trickle = TRICKLE_MAX; // [R19]
        end else begin
            next_trickle = cur_sp[TRICKLE_W-1:0]; // [R18]
        end
    end

    // ****************************************
    // Edge events
    // ****************************************
    // Clearing of a pending interrupt lives outside this block, so only edges leave here
    assign next_irq = (!batt_mask && (batt_s != batt_d)) || // [R9]
                      (!pfail_mask && (pfail_s != pfail_d)); // [R10]

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            volt_sp <= VOLT_RESET; // [R12]
            cur_sp <= CUR_RESET;
            inhibit <= INHIBIT_RESET;
            batt_mask <= BATT_MASK_RESET;
            pfail_mask <= PFAIL_MASK_RESET;
            overtemp_stop_bit <= OVERTEMP_STOP_BIT_RESET;
            hot_latch <= 1'b0;
            alarm_latch <= 1'b0;
            batt_d <= 1'b0;
            pfail_d <= 1'b0;
            dac <= '1;
            vor <= 1'b1;
            trickle <= '0;
            irq <= 1'b0;
            limit <= '0;
            unreg <= 1'b0;
        end else begin
            volt_sp <= next_volt_sp;
            cur_sp <= next_cur_sp;
            inhibit <= next_inhibit;
            batt_mask <= next_batt_mask;
            pfail_mask <= next_pfail_mask;
            overtemp_stop_bit <= next_overtemp_stop_bit;
            hot_latch <= next_hot_latch;
            alarm_latch <= next_alarm_latch;
            batt_d <= batt_s;
            pfail_d <= pfail_s;
            dac <= next_dac;
            vor <= next_vor;
            trickle <= next_trickle;
            irq <= next_irq;
            limit <= next_limit;
            unreg <= clamp_s; // [R17]
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign voltage_dac_code_o = dac;
    assign voltage_or_o = vor;
    assign voltage_setpoint_o = volt_sp;
    assign current_setpoint_o = cur_sp;
    assign current_limit_o = limit;
    assign charge_off_status_o = inhibit; // [R5]
    assign overtemp_stop_bit_o = overtemp_stop_bit;
    assign overtemp_flag_o = hot_latch;
    assign alarm_block_flag_o = alarm_latch;
    assign voltage_unregulated_flag_o = unreg; // [R17]
    assign overtemp_stop_bit_active_o = overtemp_stop_bit_cond;
    assign charger_off_o = off_cond;
    assign trickle_source_o = trickle;
    assign irq_event_o = irq;
endmodule // charger_setpoint_command_regs

// ---- logic/charger_command_host.sv ----
// Host end that issues word writes to the charger register block
`timescale 1ns/1ps
module charger_command_host
    import charger_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    word_link_if.host link,
    input wire logic req_i,
    input wire logic [7:0] cmd_i,
    input wire logic [15:0] data_i,
    output logic busy_o,
    output logic done_o
);
    // ****************************************
    // Request holding
    // ****************************************
    host_state_t state;
    host_state_t next_state;
    logic [7:0] cmd;
    logic [15:0] data;
    logic done;
    logic [7:0] next_cmd;
    logic [15:0] next_data;
    logic next_done;

    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_data = data;
        next_done = 1'b0;
        case (state)
            HOST_IDLE: begin
                if (req_i) begin
                    next_cmd = cmd_i;
                    next_data = data_i;
                    if (cmd_i == CMD_MODE) begin
                        // Unimplemented mode bits are written to their fixed levels
                        next_data = (data_i | MODE_MUST_ONE) & ~MODE_MUST_ZERO; // [R6] [R7]
                    end
                    next_state = HOST_SEND;
                end
            end
            HOST_SEND: begin
                // Command and word stay put until the charger acknowledges
                if (link.wr_ack) begin
                    next_done = 1'b1;
                    next_state = HOST_IDLE;
                end
            end
            default: next_state = HOST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= HOST_IDLE;
            cmd <= 8'h00;
            data <= 16'h0000;
            done <= 1'b0;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            data <= next_data;
            done <= next_done;
        end
    end

    // ****************************************
    // Link drive
    // ****************************************
    assign link.wr_valid = (state == HOST_SEND); // [R1] [R14] [R23]
    assign link.wr_cmd = cmd;
    assign link.wr_data = data;
    assign busy_o = (state != HOST_IDLE);
    assign done_o = done;
endmodule // charger_command_host

// ---- bench/charger_link_chk.sv ----
// Property checker for the charger command link and register outputs
`timescale 1ns/1ps
module charger_link_chk
    import charger_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic wr_valid,
    input wire logic [7:0] wr_cmd,
    input wire logic [15:0] wr_data,
    input wire logic wr_ack,
    input wire logic batt_present_i,
    input wire logic [DAC_W-1:0] voltage_dac_code_o,
    input wire logic voltage_or_o,
    input wire logic [15:0] voltage_setpoint_o,
    input wire logic [15:0] current_setpoint_o,
    input wire logic charge_off_status_o,
    input wire logic overtemp_stop_bit_o,
    input wire logic alarm_block_flag_o,
    input wire logic overtemp_stop_bit_active_o,
    input wire logic charger_off_o,
    input wire logic [TRICKLE_W-1:0] trickle_source_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Battery must be seen long enough to pass the synchronizer
    sequence batt_steady;
        batt_present_i [*4];
    endsequence
    sequence wr_to(c);
        wr_valid && wr_cmd == c;
    endsequence
    a_ack_same_cycle: assert property (wr_ack == wr_valid) else $error("ack differs from valid");
    a_valid_single: assert property (wr_valid |=> !wr_valid) else $error("valid held too long");
    a_voltage_load: assert property (batt_steady ##0 wr_to(CMD_VOLTAGE)
        |=> voltage_setpoint_o[15:4] == $past(wr_data[15:4])) else $error("voltage word not stored");
    a_current_load: assert property (wr_to(CMD_CURRENT)
        |=> current_setpoint_o == $past(wr_data)) else $error("current word not stored");
    a_dac_in_range: assert property (voltage_setpoint_o[15:14] == 2'h0
        |=> !voltage_or_o && voltage_dac_code_o == $past(voltage_setpoint_o[13:4])) else $error("dac load wrong");
    a_dac_over_range: assert property (voltage_setpoint_o[15:14] != 2'h0
        |=> voltage_or_o && (&voltage_dac_code_o)) else $error("dac not saturated");
    a_defaults_reload: assert property (batt_steady ##0 wr_to(CMD_MODE) ##0 wr_data[MODE_DEFAULTS_BIT]
        |=> voltage_setpoint_o == VOLT_DEFAULT && current_setpoint_o == CUR_DEFAULT) else $error("defaults wrong");
    a_inhibit_bit: assert property (wr_to(CMD_MODE)
        |=> charge_off_status_o == $past(wr_data[MODE_INHIBIT_BIT])) else $error("inhibit bit wrong");
    a_batt_gone: assert property (!batt_present_i [*3]
        |=> voltage_setpoint_o == VOLT_RESET && overtemp_stop_bit_o) else $error("absent battery not handled");
    a_off_sources: assert property (charger_off_o == (charge_off_status_o || overtemp_stop_bit_active_o))
        else $error("charger off wrong");
    a_trickle_off: assert property ((charge_off_status_o || alarm_block_flag_o || overtemp_stop_bit_active_o
        || current_setpoint_o == 16'h0000 || voltage_setpoint_o < VOLT_MIN_ON) |=> trickle_source_o == 5'h00)
        else $error("trickle not off");
endmodule // charger_link_chk

// ---- bench/tb_charger_setpoint_command_regs.sv ----
// Self-checking bench for the charger host link and register block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module tb_charger_setpoint_command_regs;
    import charger_pkg::*;
    localparam logic [15:0] M = MODE_MUST_ONE;
    logic clk_i = 1'b0, reset_n_i = 1'b0, req_i = 1'b0, done_o, busy_o;
    logic [7:0] cmd_i = 8'h00;
    logic [15:0] data_i = 16'h0000, voltage_setpoint_o, current_setpoint_o, current_limit_o;
    logic batt = 0, pfail = 0, hot = 0, under = 0, comp = 0, clamp = 0, alarm = 0;
    logic [1:0] sel = 2'h0;
    logic [9:0] voltage_dac_code_o;
    logic [4:0] trickle_source_o;
    logic voltage_or_o, charge_off_status_o, overtemp_stop_bit_o, overtemp_flag_o, alarm_block_flag_o;
    logic voltage_unregulated_flag_o, overtemp_stop_bit_active_o, charger_off_o, irq_event_o;
    int errors = 0, checked = 0, cycles = 0, irqs = 0, n, i;
    logic [15:0] vw [4] = '{16'h123F, 16'h3FFF, 16'h4000, 16'h8010};
    logic [15:0] cw [6] = '{16'h0005, 16'h001F, 16'h0040, 16'h0040, 16'h0040, 16'h0000};
    logic [1:0] cl [6] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h3, 2'h0};
    logic [4:0] te [6] = '{5'h05, 5'h1F, 5'h1F, 5'h00, 5'h1F, 5'h00};
    // Unused strap code falls back to the open setting
    logic [15:0] lim [4] = '{CUR_MAX_GND, CUR_MAX_OPEN, CUR_MAX_SUPPLY, CUR_MAX_OPEN};
    word_link_if link_if ();
    charger_command_host charger_command_host_inst (.clk_i, .reset_n_i, .link(link_if), .req_i, .cmd_i,
        .data_i, .busy_o, .done_o);
    charger_setpoint_command_regs charger_setpoint_command_regs_inst (.clk_i, .reset_n_i, .link(link_if),
        .batt_present_i(batt), .power_fail_i(pfail), .overtemp_i(hot), .therm_underrange_i(under),
        .comp_low_i(comp), .clamp_active_i(clamp), .alarm_set_i(alarm), .range_sel_i(sel),
        .voltage_dac_code_o, .voltage_or_o, .voltage_setpoint_o, .current_setpoint_o, .current_limit_o,
        .charge_off_status_o, .overtemp_stop_bit_o, .overtemp_flag_o, .alarm_block_flag_o,
        .voltage_unregulated_flag_o, .overtemp_stop_bit_active_o, .charger_off_o, .trickle_source_o, .irq_event_o);
    charger_link_chk charger_link_chk_inst (.clk_i, .reset_n_i, .wr_valid(link_if.wr_valid),
        .wr_cmd(link_if.wr_cmd), .wr_data(link_if.wr_data), .wr_ack(link_if.wr_ack), .batt_present_i(batt),
        .voltage_dac_code_o, .voltage_or_o, .voltage_setpoint_o, .current_setpoint_o, .charge_off_status_o,
        .overtemp_stop_bit_o, .alarm_block_flag_o, .overtemp_stop_bit_active_o, .charger_off_o, .trickle_source_o);
    always #5 clk_i = ~clk_i;
    // Ceiling well above the roughly 180 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (irq_event_o === 1'b1) irqs++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end
    task complete_run;
        $display("counts errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_i);
        req_i <= 1'b1;
        cmd_i <= c;
        data_i <= d;
        @(posedge clk_i);
        req_i <= 1'b0;
        // Look after the edge so the done pulse is settled
        #1;
        n = 0;
        while (done_o !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHK("write done", 1'b1, done_o)
        `CHK("host busy", 1'b0, busy_o)
        settle(1);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        settle(2);
        `CHK("voltage set point", VOLT_RESET, voltage_setpoint_o)
        `CHK("overtemp_stop_bit bit", OVERTEMP_STOP_BIT_RESET, overtemp_stop_bit_o)
        `CHK("inhibit", INHIBIT_RESET, charge_off_status_o)
        $display("test reset done");
        @(posedge clk_i);
        batt <= 1'b1;
        settle(4);
        for (i = 0; i < 4; i++) begin
            wr(CMD_VOLTAGE, vw[i]);
            `CHK("voltage dac", vw[i][15:14] != 2'h0 ? 10'h3FF : vw[i][13:4], voltage_dac_code_o)
            `CHK("voltage over range", |vw[i][15:14], voltage_or_o)
        end
        $display("test voltage done");
        for (i = 0; i < 6; i++) begin
            @(posedge clk_i);
            comp <= cl[i][1];
            clamp <= cl[i][0];
            settle(4);
            wr(CMD_CURRENT, cw[i]);
            `CHK("unregulated flag", cl[i][0], voltage_unregulated_flag_o)
            `CHK("trickle", te[i], trickle_source_o)
        end
        wr(CMD_CURRENT, 16'h0010);
        wr(CMD_VOLTAGE, 16'h000F);
        `CHK("trickle low voltage", 5'h00, trickle_source_o)
        wr(CMD_VOLTAGE, 16'h0010);
        `CHK("trickle min voltage", 5'h10, trickle_source_o)
        wr(CMD_CURRENT, 16'hFFFF);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            sel <= i[1:0];
            settle(4);
            `CHK("current limit", lim[i], current_limit_o)
        end
        $display("test current done");
        wr(CMD_MODE, M | 16'h0001);
        `CHK("charger off", 1'b1, charger_off_o)
        wr(CMD_MODE, M);
        `CHK("charger on", 1'b0, charger_off_o)
        @(posedge clk_i);
        hot <= 1'b1;
        alarm <= 1'b1;
        settle(4);
        `CHK("hot without stop bit", 1'b0, overtemp_stop_bit_active_o)
        `CHK("alarm trickle", 5'h00, trickle_source_o)
        wr(CMD_MODE, M | 16'h0400);
        `CHK("overtemp_stop_bit", 1'b1, charger_off_o)
        @(posedge clk_i);
        under <= 1'b1;
        hot <= 1'b0;
        alarm <= 1'b0;
        settle(4);
        `CHK("under range", 1'b0, overtemp_stop_bit_active_o)
        wr(CMD_MODE, M | 16'h0004);
        `CHK("hot latch", 1'b0, overtemp_flag_o)
        `CHK("alarm latch", 1'b0, alarm_block_flag_o)
        `CHK("current default", CUR_DEFAULT, current_setpoint_o)
        wr(8'h13, 16'h0000);
        `CHK("unmapped write", VOLT_DEFAULT, voltage_setpoint_o)
        $display("test mode done");
        irqs = 0;
        @(posedge clk_i);
        pfail <= 1'b1;
        settle(6);
        `CHK("power fail irq", 1, irqs)
        wr(CMD_MODE, M | 16'h0060);
        irqs = 0;
        @(posedge clk_i);
        pfail <= 1'b0;
        batt <= 1'b0;
        settle(6);
        `CHK("masked irq", 0, irqs)
        `CHK("absent voltage", VOLT_RESET, voltage_setpoint_o)
        `CHK("absent overtemp_stop_bit", 1'b1, overtemp_stop_bit_o)
        wr(CMD_MODE, M);
        irqs = 0;
        @(posedge clk_i);
        batt <= 1'b1;
        settle(6);
        `CHK("battery irq", 1, irqs)
        $display("test irq done");
        complete_run();
    end
endmodule // tb_charger_setpoint_command_regs
